// *** elapsed_timer_pkg.sv ***
// ==========================================================================
// Register map, field layout, reset values and timing for the elapsed timer
package elapsed_timer_pkg;

    // ======================================================================
    // Register offsets (byte addresses)
    localparam logic [7:0]  MODE_OFFSET       = 8'h00;
    localparam logic [7:0]  ALARM_OFFSET      = 8'h04;
    localparam logic [7:0]  COUNT_OFFSET      = 8'h08;
    localparam logic [7:0]  STATUS_OFFSET     = 8'h0C;
    localparam logic [7:0]  IRQ_CLEAR_OFFSET  = 8'h10;
    localparam logic [7:0]  IRQ_ENABLE_OFFSET = 8'h14;

    // ======================================================================
    // Field positions
    localparam int PRESCALE_LSB     = 0;
    localparam int PRESCALE_MSB     = 15;
    localparam int ALARM_IEN_BIT    = 16;
    localparam int TICK_IEN_BIT     = 17;
    localparam int RESTART_BIT      = 18;
    localparam int ALARM_FLAG_BIT   = 0;
    localparam int TICK_FLAG_BIT    = 1;

    // ======================================================================
    // Reset values
    localparam logic [15:0] PRESCALE_RESET  = 16'h8000;
    localparam logic [31:0] MODE_RESET      = 32'h0000_8000;
    localparam logic [31:0] ALARM_RESET     = 32'hFFFF_FFFF;
    localparam logic [31:0] COUNT_RESET     = 32'h0000_0000;

    // ======================================================================
    // Timing
    localparam logic [16:0] ZERO_PERIOD     = 17'h1_0000;
    localparam logic [1:0]  CROSS_SLOW_EDGES = 2'h2;

    // Mode register contents
    typedef struct packed {
        logic        tickIrqEnable;
        logic        alarmIrqEnable;
        logic [15:0] prescaleValue;
    } mode_t;

    // Sticky event flags, same layout in status, clear and enable registers
    typedef struct packed {
        logic tickFlag;
        logic alarmFlag;
    } events_t;

endpackage

// *** slow_clock_elapsed_time_counter.sv ***
// Local design decision: the APB register port.
`timescale 1ns/10ps
module slow_clock_elapsed_time_counter
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        slowClock,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             irq
);

    // ======================================================================
    // Decode helpers
    function automatic logic regHit(input logic [7:0] addr, input logic [7:0] offset);
        regHit = (addr == offset);
    endfunction

    function automatic logic [16:0] periodOf(input logic [15:0] prescale);
        periodOf = (prescale == 16'h0000) ? elapsed_timer_pkg::ZERO_PERIOD
                                          : {1'b0, prescale};
    endfunction

    // ======================================================================
    // State
    elapsed_timer_pkg::mode_t   mode;
    elapsed_timer_pkg::events_t flags;
    logic [31:0] alarmSetting;
    logic [31:0] liveCount;
    logic [16:0] divCount;
    logic        slowSync1;
    logic        slowSync2;
    logic        slowPrev;
    logic        slowEdge;
    logic        tick;
    logic [1:0]  restartWait;
    logic [1:0]  clearWait;
    logic        restartApply;
    logic        clearApply;
    logic        matchPrev;
    logic        countMatch;
    logic        alarmEvent;
    logic        setupPhase;
    logic        accessDone;
    logic        writeDone;
    logic        statusReadDone;
    logic        mapped;
    logic        clearWrite;
    logic [1:0]  restartEdges;

    // ======================================================================
    // Slow clock synchroniser and edge detect
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            slowSync1 <= 1'b0;
            slowSync2 <= 1'b0;
            slowPrev  <= 1'b0;
        end
        else
        begin
            slowSync1 <= slowClock;
            slowSync2 <= slowSync1;
            slowPrev  <= slowSync2;
        end
    end

    // One core cycle per slow clock rising edge
    assign slowEdge = slowSync2 & ~slowPrev;

    // ======================================================================
    // APB decode
    assign setupPhase     = psel & ~penable;
    assign accessDone     = psel & penable;
    assign writeDone      = accessDone & pwrite;
    assign statusReadDone = accessDone & ~pwrite
                            & regHit(paddr, elapsed_timer_pkg::STATUS_OFFSET);
    assign clearWrite     = writeDone
                            & regHit(paddr, elapsed_timer_pkg::IRQ_CLEAR_OFFSET);
    assign mapped = regHit(paddr, elapsed_timer_pkg::MODE_OFFSET)
                  | regHit(paddr, elapsed_timer_pkg::ALARM_OFFSET)
                  | regHit(paddr, elapsed_timer_pkg::COUNT_OFFSET)
                  | regHit(paddr, elapsed_timer_pkg::STATUS_OFFSET)
                  | regHit(paddr, elapsed_timer_pkg::IRQ_CLEAR_OFFSET)
                  | regHit(paddr, elapsed_timer_pkg::IRQ_ENABLE_OFFSET);

    // Answer in the access phase; read data was captured in setup
    assign pready = 1'b1;

    // Read data and error captured in the setup cycle
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setupPhase)
        begin
            pslverr <= ~mapped;
            prdata  <= 32'h0000_0000;
            if (!pwrite)
            begin
                unique case (1'b1)
                    regHit(paddr, elapsed_timer_pkg::MODE_OFFSET):
                        prdata <= {14'h0000, mode};
                    regHit(paddr, elapsed_timer_pkg::ALARM_OFFSET):
                        prdata <= alarmSetting;
                    regHit(paddr, elapsed_timer_pkg::COUNT_OFFSET):
                        prdata <= liveCount;
                    regHit(paddr, elapsed_timer_pkg::STATUS_OFFSET):
                        prdata <= {30'h0000_0000, flags};
                    regHit(paddr, elapsed_timer_pkg::IRQ_ENABLE_OFFSET):
                        prdata <= {30'h0000_0000, mode.tickIrqEnable,
                                   mode.alarmIrqEnable};
                    default:
                        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ======================================================================
    // Mode register; the restart bit is a strobe and reads as zero
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            mode.prescaleValue  <= elapsed_timer_pkg::PRESCALE_RESET;
            mode.alarmIrqEnable <= 1'b0;
            mode.tickIrqEnable  <= 1'b0;
        end
        else if (writeDone && regHit(paddr, elapsed_timer_pkg::MODE_OFFSET))
        begin
            mode.prescaleValue <= pwdata[elapsed_timer_pkg::PRESCALE_MSB:
                                         elapsed_timer_pkg::PRESCALE_LSB];
            mode.alarmIrqEnable <= pwdata[elapsed_timer_pkg::ALARM_IEN_BIT];
            mode.tickIrqEnable  <= pwdata[elapsed_timer_pkg::TICK_IEN_BIT];
        end
        else if (writeDone && regHit(paddr, elapsed_timer_pkg::IRQ_ENABLE_OFFSET))
        begin
            mode.alarmIrqEnable <= pwdata[elapsed_timer_pkg::ALARM_FLAG_BIT];
            mode.tickIrqEnable  <= pwdata[elapsed_timer_pkg::TICK_FLAG_BIT];
        end
    end

    // Alarm setting
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            alarmSetting <= elapsed_timer_pkg::ALARM_RESET;
        else if (writeDone && regHit(paddr, elapsed_timer_pkg::ALARM_OFFSET))
            alarmSetting <= pwdata;
    end

    // ======================================================================
    // Restart request waits two slow edges before acting
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            restartWait <= 2'h0;
        else if (writeDone && regHit(paddr, elapsed_timer_pkg::MODE_OFFSET)
                 && pwdata[elapsed_timer_pkg::RESTART_BIT])
            restartWait <= elapsed_timer_pkg::CROSS_SLOW_EDGES;
        else if (slowEdge && restartWait != 2'h0)
            restartWait <= restartWait - 2'h1;
    end

    assign restartApply = slowEdge && (restartWait == 2'h1);

    // Status clear request waits two slow edges after the read
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            clearWait <= 2'h0;
        else if (statusReadDone)
            clearWait <= elapsed_timer_pkg::CROSS_SLOW_EDGES;
        else if (slowEdge && clearWait != 2'h0)
            clearWait <= clearWait - 2'h1;
    end

    assign clearApply = slowEdge && (clearWait == 2'h1);

    // ======================================================================
    // Prescaler: counts slow edges up to the programmed period
    // A shorter new period ends the running one on the next slow edge instead of wrapping 17 bits
    assign tick = slowEdge
                  && (divCount >= periodOf(mode.prescaleValue) - 17'h0_0001);

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            divCount <= 17'h0_0000;
        else if (restartApply)
            divCount <= 17'h0_0000;
        else if (tick)
            divCount <= 17'h0_0000;
        else if (slowEdge)
            divCount <= divCount + 17'h0_0001;
    end

    // Elapsed counter, wraps naturally at 32 bits
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            liveCount <= elapsed_timer_pkg::COUNT_RESET;
        else if (restartApply)
            liveCount <= elapsed_timer_pkg::COUNT_RESET;
        else if (tick)
            liveCount <= liveCount + 32'h0000_0001;
    end

    // ======================================================================
    // Alarm compare against setting plus one, on the rising match
    // Compared in 33 bits so the all-ones reset setting never matches
    assign countMatch = ({1'b0, liveCount} == {1'b0, alarmSetting} + 33'h0_0000_0001);
    assign alarmEvent = countMatch & ~matchPrev;

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            matchPrev <= 1'b0;
        else
            matchPrev <= countMatch;
    end

    // Sticky flags; a new event wins over a clear in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            flags <= 2'b00;
        else
        begin
            if (alarmEvent)
                flags.alarmFlag <= 1'b1;
            else if (clearApply)
                flags.alarmFlag <= 1'b0;
            else if (writeDone && regHit(paddr, elapsed_timer_pkg::IRQ_CLEAR_OFFSET)
                     && pwdata[elapsed_timer_pkg::ALARM_FLAG_BIT])
                flags.alarmFlag <= 1'b0;
            if (tick)
                flags.tickFlag <= 1'b1;
            else if (clearApply)
                flags.tickFlag <= 1'b0;
            else if (writeDone && regHit(paddr, elapsed_timer_pkg::IRQ_CLEAR_OFFSET)
                     && pwdata[elapsed_timer_pkg::TICK_FLAG_BIT])
                flags.tickFlag <= 1'b0;
        end
    end

    // ======================================================================
    // Interrupt output from flag and enable flops
    assign irq = (flags.alarmFlag & mode.alarmIrqEnable)
               | (flags.tickFlag & mode.tickIrqEnable);

    // ======================================================================
    // Check helper: slow edges seen since the latest restart write
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            restartEdges <= 2'h0;
        else if (writeDone && regHit(paddr, elapsed_timer_pkg::MODE_OFFSET)
                 && pwdata[elapsed_timer_pkg::RESTART_BIT])
            restartEdges <= 2'h0;
        else if (slowEdge && restartEdges != 2'h3)
            restartEdges <= restartEdges + 2'h1;
    end

    // ======================================================================
    // Checks
    a_tick_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
        tick |=> flags.tickFlag)
        else $error("tick flag not set after counter advance");

    a_count_advance: assert property (@(posedge core_clk) disable iff (!rst_b)
        tick && !restartApply |=> liveCount == $past(liveCount) + 32'h0000_0001)
        else $error("counter did not advance by one on tick");

    a_count_wrap: assert property (@(posedge core_clk) disable iff (!rst_b)
        tick && liveCount == 32'hFFFF_FFFF |=> liveCount == 32'h0000_0000)
        else $error("counter did not wrap to zero");

    a_period_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
        tick && mode.prescaleValue == 16'h0000 |-> divCount == 17'h0_FFFF)
        else $error("zero prescale period wrong");

    a_alarm_plus_one: assert property (@(posedge core_clk) disable iff (!rst_b)
        tick && !restartApply && liveCount == alarmSetting
        && alarmSetting != 32'hFFFF_FFFF |=> ##1 flags.alarmFlag)
        else $error("alarm flag not set on setting plus one");

    a_alarm_event: assert property (@(posedge core_clk) disable iff (!rst_b)
        alarmEvent |=> flags.alarmFlag)
        else $error("alarm flag not set on match");

    a_alarm_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        flags.alarmFlag && !clearApply
        && !(clearWrite && pwdata[elapsed_timer_pkg::ALARM_FLAG_BIT]) |=> flags.alarmFlag)
        else $error("alarm flag dropped without a clear");

    a_tick_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        flags.tickFlag && !clearApply
        && !(clearWrite && pwdata[elapsed_timer_pkg::TICK_FLAG_BIT]) |=> flags.tickFlag)
        else $error("tick flag dropped without a clear");

    a_clear_alarm: assert property (@(posedge core_clk) disable iff (!rst_b)
        clearApply && !alarmEvent |=> !flags.alarmFlag)
        else $error("alarm flag not cleared by status read");

    a_clear_tick: assert property (@(posedge core_clk) disable iff (!rst_b)
        clearApply && !tick |=> !flags.tickFlag)
        else $error("tick flag not cleared by status read");

    a_irq_masked: assert property (@(posedge core_clk) disable iff (!rst_b)
        !mode.alarmIrqEnable && !mode.tickIrqEnable |-> !irq)
        else $error("interrupt raised with both enables cleared");

    a_irq_alarm: assert property (@(posedge core_clk) disable iff (!rst_b)
        flags.alarmFlag && mode.alarmIrqEnable |-> irq)
        else $error("enabled alarm flag did not raise interrupt");

    a_irq_tick: assert property (@(posedge core_clk) disable iff (!rst_b)
        flags.tickFlag && mode.tickIrqEnable |-> irq)
        else $error("enabled tick flag did not raise interrupt");

    a_alarm_reset: assert property (@(posedge core_clk)
        $past(!rst_b) |-> alarmSetting == 32'hFFFF_FFFF && mode == 18'h0_8000)
        else $error("alarm or mode reset value wrong");

    a_reset_quiet: assert property (@(posedge core_clk)
        $past(!rst_b) |-> prdata == 32'h0000_0000 && !pslverr && !irq)
        else $error("outputs not quiet after reset");

    a_count_steady: assert property (@(posedge core_clk) disable iff (!rst_b)
        !tick && !restartApply |=> $stable(liveCount))
        else $error("counter moved without a tick");

    a_read_no_effect: assert property (@(posedge core_clk) disable iff (!rst_b)
        accessDone && !pwrite && regHit(paddr, elapsed_timer_pkg::COUNT_OFFSET)
        && !tick && !alarmEvent && !clearApply |=> $stable(flags))
        else $error("count read disturbed the flags");

    a_rdata_stands: assert property (@(posedge core_clk) disable iff (!rst_b)
        !setupPhase |=> $stable(prdata))
        else $error("read data changed outside a setup cycle");

    a_restart_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
        restartApply |=> liveCount == 32'h0000_0000 && divCount == 17'h0_0000)
        else $error("restart did not zero counter");

    a_clear_lag: assert property (@(posedge core_clk) disable iff (!rst_b)
        statusReadDone && flags.tickFlag && !clearApply |=> flags.tickFlag)
        else $error("status flags cleared too early");

    a_restart_lag: assert property (@(posedge core_clk) disable iff (!rst_b)
        restartApply |-> $past(restartWait) == 2'h1)
        else $error("restart applied before two slow edges");

    a_restart_edges: assert property (@(posedge core_clk) disable iff (!rst_b)
        restartApply |-> restartEdges == 2'h1)
        else $error("restart not on second slow edge after write");

endmodule // slow_clock_elapsed_time_counter

// *** test_slow_clock_elapsed_time_counter.sv ***
`timescale 1ns/10ps
module test_slow_clock_elapsed_time_counter;

    // ======================================================================
    // Signals
    logic        core_clk;
    logic        rst_b;
    logic        slowClock;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq;
    logic [3:0]  slowDiv;
    logic [31:0] rdData;
    logic        rdErr;
    logic [31:0] firstCount;
    int          failures;
    int          numChecks;

    slow_clock_elapsed_time_counter dut_u
    (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .slowClock(slowClock),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .pready   (pready),
        .prdata   (prdata),
        .pslverr  (pslverr),
        .irq      (irq)
    );

    // ======================================================================
    // Clocks: core at 50 MHz, slow clock at one sixteenth of it
    always #10 core_clk = ~core_clk;

    // Slow clock divider, parked low during reset
    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            slowDiv   <= 4'h0;
            slowClock <= 1'b0;
        end
        else
        begin
            slowDiv   <= slowDiv + 4'h1;
            slowClock <= slowDiv[3];
        end
    end

    // ======================================================================
    // Bus and check tasks
    // One APB transfer; read data and error are taken at the pready edge
    task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            failures++;
            $display("[FAIL] pready expected 1 seen %b", pready);
        end
        rdData = prdata;
        rdErr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Interrupt is looked at mid-cycle, after the edge has settled
    task check_irq(input string name, input logic exp);
        @(negedge core_clk);
        check(name, {31'h0, exp}, {31'h0, irq});
    endtask

    task print_verdict;
        if (failures == 0 && numChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ======================================================================
    // Watchdog cuts a hang short
    initial
    begin
        repeat (20000) @(posedge core_clk);
        failures++;
        print_verdict();
    end

    // ======================================================================
    // Test sequence
    initial
    begin
        int presTab[3];
        int n;
        presTab = '{1, 3, 7};
        core_clk = 1'b0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        failures = 0;
        numChecks = 0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        check_irq("irq after reset", 1'b0);
        apb(1'b0, elapsed_timer_pkg::MODE_OFFSET, 32'h0);
        check("mode reset", elapsed_timer_pkg::MODE_RESET, rdData);
        apb(1'b0, elapsed_timer_pkg::ALARM_OFFSET, 32'h0);
        check("alarm reset", elapsed_timer_pkg::ALARM_RESET, rdData);
        apb(1'b0, elapsed_timer_pkg::COUNT_OFFSET, 32'h0);
        check("count reset", elapsed_timer_pkg::COUNT_RESET, rdData);
        apb(1'b0, elapsed_timer_pkg::STATUS_OFFSET, 32'h0);
        check("status reset", 32'h0, rdData);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped error", 32'h1, {31'h0, rdErr});
        check("unmapped data", 32'h0, rdData);
        // Exactly one advance per prescale period of slow clock cycles
        foreach (presTab[i])
        begin
            apb(1'b1, elapsed_timer_pkg::MODE_OFFSET, {13'h0, 3'b100, presTab[i][15:0]});
            repeat (80) @(posedge core_clk);
            apb(1'b0, elapsed_timer_pkg::COUNT_OFFSET, 32'h0);
            firstCount = rdData;
            repeat (16 * presTab[i] - 3) @(posedge core_clk);
            apb(1'b0, elapsed_timer_pkg::COUNT_OFFSET, 32'h0);
            check("count step", firstCount + 32'h1, rdData);
            apb(1'b0, elapsed_timer_pkg::MODE_OFFSET, 32'h0);
            check("mode readback", {16'h0, presTab[i][15:0]}, rdData);
        end
        // Count is read-only; restart clears it two slow cycles later
        apb(1'b1, elapsed_timer_pkg::COUNT_OFFSET, 32'h0);
        check("count write error", 32'h0, {31'h0, rdErr});
        apb(1'b1, elapsed_timer_pkg::MODE_OFFSET, {13'h0, 3'b100, 16'h0005});
        apb(1'b0, elapsed_timer_pkg::COUNT_OFFSET, 32'h0);
        check("count before restart", 32'h1, {31'h0, rdData != 32'h0});
        repeat (57) @(posedge core_clk);
        apb(1'b0, elapsed_timer_pkg::COUNT_OFFSET, 32'h0);
        check("count after restart", 32'h0, rdData);
        // Alarm fires at setting plus one, with its interrupt enabled
        apb(1'b1, elapsed_timer_pkg::ALARM_OFFSET, 32'h2);
        apb(1'b1, elapsed_timer_pkg::MODE_OFFSET, {13'h0, 3'b101, 16'h0003});
        n = 0;
        do
        begin
            apb(1'b0, elapsed_timer_pkg::COUNT_OFFSET, 32'h0);
            n++;
        end
        while (rdData !== 32'h2 && n < 200);
        apb(1'b0, elapsed_timer_pkg::STATUS_OFFSET, 32'h0);
        check("alarm at setting", 32'h0, {31'h0, rdData[0]});
        check_irq("irq before alarm", 1'b0);
        n = 0;
        do
        begin
            apb(1'b0, elapsed_timer_pkg::COUNT_OFFSET, 32'h0);
            n++;
        end
        while (rdData === 32'h2 && n < 200);
        check_irq("irq on alarm", 1'b1);
        apb(1'b0, elapsed_timer_pkg::STATUS_OFFSET, 32'h0);
        check("alarm flag", 32'h1, {31'h0, rdData[0]});
        check_irq("irq held after read", 1'b1);
        repeat (64) @(posedge core_clk);
        check_irq("irq after clear", 1'b0);
        apb(1'b0, elapsed_timer_pkg::STATUS_OFFSET, 32'h0);
        check("alarm cleared", 32'h0, {31'h0, rdData[0]});
        // Tick enable set through the enable register; it reads back in mode
        apb(1'b1, elapsed_timer_pkg::IRQ_ENABLE_OFFSET, 32'h2);
        apb(1'b0, elapsed_timer_pkg::MODE_OFFSET, 32'h0);
        check("enable alias", {14'h0, 2'b10, 16'h0003}, rdData);
        // Let the pending clear land, then line up on the next tick
        repeat (40) @(posedge core_clk);
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while (irq !== 1'b1 && n < 200);
        check_irq("irq on tick", 1'b1);
        apb(1'b1, elapsed_timer_pkg::IRQ_CLEAR_OFFSET, 32'h3);
        check_irq("irq after clear write", 1'b0);
        apb(1'b1, elapsed_timer_pkg::IRQ_ENABLE_OFFSET, 32'h0);
        repeat (60) @(posedge core_clk);
        apb(1'b0, elapsed_timer_pkg::STATUS_OFFSET, 32'h0);
        check("tick flag", 32'h1, {31'h0, rdData[1]});
        check_irq("irq masked", 1'b0);
        print_verdict();
    end

endmodule // test_slow_clock_elapsed_time_counter
